// ===== core/hcs_pkg.sv
// Package of constants for the host command/status port
package hcs_pkg;
  localparam logic [15:0] HOST_DATA_BYTE_OFS = 16'hfe00;
  localparam logic [15:0] COMMAND_BYTE_OFS = 16'hfe01;
  localparam logic [15:0] STATUS_BYTE_OFS = 16'hfe01;
  localparam logic REG_SEL_DATA = 1'b0;
  localparam logic REG_SEL_CMD = 1'b1;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_RESET_VAL = 8'h00;
  localparam logic [7:0] DATA_RESET_VAL = 8'h00;
  localparam int ST_READY_POS = 0;
  localparam int ST_CARD_BUSY_POS = 1;
  localparam int ST_KEY_AVAIL_POS = 2;
  localparam int ST_USB_BUSY_POS = 3;
  localparam int ST_USB_FULL_POS = 4;
  localparam int ST_USB_PEND_POS = 5;
  localparam logic [1:0] ST_RESERVED_VAL = 2'h0;
  localparam int CLK_HZ = 50000000;
  localparam int POWERUP_US = 100;
  localparam int POWERUP_CYCLES = (CLK_HZ / 1000000) * POWERUP_US;
  typedef enum logic [1:0] {
    HCS_POWERUP = 2'b00,
    HCS_IDLE = 2'b01,
    HCS_ACTIVE = 2'b11
  } hcs_state_e;
endpackage

// ===== core/hcs_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module hcs_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic [2:0] stage;
    logic out;
  } hcs_sync_s;
  hcs_sync_s st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.stage = {st_r.stage[1:0], async_in};
    if (st_r.stage[2] == st_r.stage[1]) begin
      st_nxt.out = st_r.stage[2];
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{stage: {3{RESET_VAL}}, out: RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign sync_out = st_r.out;
endmodule

// ===== core/hcs_port.sv
// Byte-wide host command/status port with command sequencer
`timescale 1ns/100ps
// How it works
// - Two host registers: data byte and a shared command/status location.
// - Writes to the shared location load command; reads return status.
// - Result bytes are presented on the data register for host reads.
// - A NOP closes a command; device is then ready for the next.
// - Ready bit clears on reset, sets when power-up sequence ends.
// - Status bit 1 reflects flash card busy.
// - Status bit 2 reflects keyboard buffer holding unread data.
// - Status bit 3 reflects USB busy; host avoids USB commands then.
// - Status bit 4 reflects USB write buffer full.
// - Status bit 5 reflects USB data still pending to send.
// - Status bits 7 and 6 reserved; they read as zero here.
// - Command codes are eight bits; undefined codes are reserved.
// - Register select chooses data or command/status per access.
// - Strobes count only while device select is low.
// - Host data bus is bidirectional tri-state, in/out/enable.
module hcs_port #(
  parameter int POWERUP_COUNT = hcs_pkg::POWERUP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic device_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic register_select_line,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe,
  input wire logic flash_card_busy,
  input wire logic key_data_available,
  input wire logic usb_busy,
  input wire logic usb_buffer_full,
  input wire logic usb_data_pending,
  input wire logic [7:0] result_byte,
  input wire logic result_valid,
  output logic [7:0] command_byte,
  output logic command_strobe,
  output logic [7:0] argument_byte,
  output logic argument_strobe,
  output logic result_taken,
  output logic command_active,
  output logic [7:0] status_byte
);
  import hcs_pkg::*;

  localparam int CNT_W = $clog2(POWERUP_COUNT + 1);

  logic cs_n_s, rd_n_s, wr_n_s, sel_s;

  hcs_sync #(.RESET_VAL(1'b1)) u_sync_cs (.clk_sys(clk_sys), .reset_n(reset_n),
    .async_in(device_select_n), .sync_out(cs_n_s));
  hcs_sync #(.RESET_VAL(1'b1)) u_sync_rd (.clk_sys(clk_sys), .reset_n(reset_n),
    .async_in(read_strobe_n), .sync_out(rd_n_s));
  hcs_sync #(.RESET_VAL(1'b1)) u_sync_wr (.clk_sys(clk_sys), .reset_n(reset_n),
    .async_in(write_strobe_n), .sync_out(wr_n_s));
  hcs_sync #(.RESET_VAL(1'b0)) u_sync_sel (.clk_sys(clk_sys), .reset_n(reset_n),
    .async_in(register_select_line), .sync_out(sel_s));

  typedef struct packed {
    hcs_state_e state;
    logic [CNT_W-1:0] pwr_cnt;
    logic [7:0] din_q1;
    logic [7:0] din_q2;
    logic wr_n_d;
    logic rd_n_d;
    logic [7:0] din_d;
    logic [7:0] cmd;
    logic cmd_stb;
    logic [7:0] arg;
    logic arg_stb;
    logic res_taken;
    logic [7:0] dout;
    logic oe;
    logic [7:0] status;
    logic active;
  } hcs_port_s;

  hcs_port_s st_r, st_nxt;

  logic wr_rise, rd_fall, rd_on, nop_now;

  always_comb begin
    st_nxt = st_r;
    // Data pins pass three stages; the byte latched with the strobe is stable by then
    st_nxt.din_q1 = host_data_bus_in;
    st_nxt.din_q2 = st_r.din_q1;
    st_nxt.din_d = st_r.din_q2;
    st_nxt.wr_n_d = wr_n_s;
    st_nxt.rd_n_d = rd_n_s;
    st_nxt.cmd_stb = 1'b0;
    st_nxt.arg_stb = 1'b0;
    st_nxt.res_taken = 1'b0;
    wr_rise = wr_n_s && !st_r.wr_n_d && !cs_n_s;
    rd_on = !cs_n_s && !rd_n_s;
    rd_fall = rd_on && st_r.rd_n_d;
    nop_now = (st_r.cmd == CMD_NOP);
    // Power-up sequence, restarted by every reset
    if (st_r.state == HCS_POWERUP) begin
      if (st_r.pwr_cnt == CNT_W'(POWERUP_COUNT - 1)) begin
        st_nxt.state = HCS_IDLE;
      end else begin
        st_nxt.pwr_cnt = st_r.pwr_cnt + CNT_W'(1);
      end
    end else if (wr_rise) begin
      if (sel_s == REG_SEL_CMD) begin
        st_nxt.cmd = st_r.din_d;
        st_nxt.cmd_stb = (st_r.din_d != CMD_NOP);
        st_nxt.state = (st_r.din_d == CMD_NOP) ? HCS_IDLE : HCS_ACTIVE;
      end else if (!nop_now) begin
        st_nxt.arg = st_r.din_d;
        st_nxt.arg_stb = 1'b1;
      end
    end
    // Reads: data register gives result while a command runs; shared location gives status
    if (sel_s == REG_SEL_DATA) begin
      st_nxt.dout = result_valid ? result_byte : DATA_RESET_VAL;
      st_nxt.oe = rd_on && !nop_now;
      st_nxt.res_taken = rd_fall && !nop_now && result_valid && (st_r.state == HCS_ACTIVE);
    end else begin
      st_nxt.dout = st_r.status;
      st_nxt.oe = rd_on;
    end
    st_nxt.status = {ST_RESERVED_VAL,
      usb_data_pending,
      usb_buffer_full,
      usb_busy,
      key_data_available,
      flash_card_busy,
      st_nxt.state != HCS_POWERUP};
    st_nxt.active = (st_nxt.state == HCS_ACTIVE);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{state: HCS_POWERUP, pwr_cnt: '0, wr_n_d: 1'b1, rd_n_d: 1'b1,
        din_q1: DATA_RESET_VAL, din_q2: DATA_RESET_VAL,
        din_d: DATA_RESET_VAL, cmd: CMD_RESET_VAL, cmd_stb: 1'b0, arg: DATA_RESET_VAL,
        arg_stb: 1'b0, res_taken: 1'b0, dout: DATA_RESET_VAL, oe: 1'b0,
        status: DATA_RESET_VAL, active: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign host_data_bus_out = st_r.dout;
  assign host_data_bus_oe = st_r.oe;
  assign command_byte = st_r.cmd;
  assign command_strobe = st_r.cmd_stb;
  assign argument_byte = st_r.arg;
  assign argument_strobe = st_r.arg_stb;
  assign result_taken = st_r.res_taken;
  assign command_active = st_r.active;
  assign status_byte = st_r.status;

  sequence s_wr_rise;
    !st_r.wr_n_d && wr_n_s && !cs_n_s;
  endsequence

  property p_ready_after_powerup;
    @(posedge clk_sys) disable iff (!reset_n)
      (st_r.state == HCS_POWERUP) |-> !status_byte[ST_READY_POS];
  endproperty
  a_ready_after_powerup: assert property (p_ready_after_powerup)
    else $error("ready set during power-up");

  property p_ready_sticky;
    @(posedge clk_sys) disable iff (!reset_n)
      status_byte[ST_READY_POS] |=> status_byte[ST_READY_POS];
  endproperty
  a_ready_sticky: assert property (p_ready_sticky)
    else $error("ready cleared without reset");

  property p_card_busy;
    @(posedge clk_sys) disable iff (!reset_n)
      ##1 status_byte[ST_CARD_BUSY_POS] == $past(flash_card_busy);
  endproperty
  a_card_busy: assert property (p_card_busy)
    else $error("card busy bit wrong");

  property p_usb_bits;
    @(posedge clk_sys) disable iff (!reset_n)
      ##1 status_byte[5:2] == $past({usb_data_pending, usb_buffer_full, usb_busy,
        key_data_available});
  endproperty
  a_usb_bits: assert property (p_usb_bits)
    else $error("status bits 5..2 wrong");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!reset_n) status_byte[7:6] == ST_RESERVED_VAL;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");

  property p_oe_only_on_read;
    @(posedge clk_sys) disable iff (!reset_n)
      host_data_bus_oe |-> $past(!cs_n_s && !rd_n_s);
  endproperty
  a_oe_only_on_read: assert property (p_oe_only_on_read)
    else $error("bus driven outside read");

  property p_nop_no_arg;
    @(posedge clk_sys) disable iff (!reset_n)
      (command_byte == CMD_NOP) |=> !argument_strobe || $past(command_byte) != CMD_NOP;
  endproperty
  a_nop_no_arg: assert property (p_nop_no_arg)
    else $error("argument taken under nop");

  property p_cmd_load;
    @(posedge clk_sys) disable iff (!reset_n)
      s_wr_rise ##0 ((sel_s == REG_SEL_CMD) && (st_r.state != HCS_POWERUP))
        |=> command_byte == $past(st_r.din_d);
  endproperty
  a_cmd_load: assert property (p_cmd_load)
    else $error("command not loaded");

  property p_nop_idle;
    @(posedge clk_sys) disable iff (!reset_n)
      (command_byte == CMD_NOP) |-> !command_active && !command_strobe;
  endproperty
  a_nop_idle: assert property (p_nop_idle)
    else $error("activity under nop");
endmodule

// ===== sim/hcs_host_model.sv
// Host bus master model for the command/status port pins
`timescale 1ns/100ps
module hcs_host_model (
  input wire logic clk_sys,
  output logic device_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic register_select_line,
  output wire logic [7:0] host_data_bus_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_data_bus_oe,
  output logic rd_done,
  output logic [8:0] rd_val
);
  logic [7:0] drv;
  assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : drv;
  initial begin
    {device_select_n, read_strobe_n, write_strobe_n, register_select_line} = 4'he;
    drv = 8'h5a;
    {rd_done, rd_val} = 10'h000;
  end
  // Strobe low 8 cycles, select and data held 6 more, then a gap
  task automatic access(input logic cs, input logic sel, input logic wr, input logic [7:0] d);
    @(posedge clk_sys);
    device_select_n <= ~cs;
    register_select_line <= sel;
    drv <= d;
    write_strobe_n <= ~wr;
    read_strobe_n <= wr;
    repeat (8) @(posedge clk_sys);
    rd_val <= host_data_bus_oe ? {1'b1, host_data_bus_out} : 9'h000;
    rd_done <= ~wr;
    write_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    @(posedge clk_sys);
    rd_done <= 1'b0;
    repeat (5) @(posedge clk_sys);
    device_select_n <= 1'b1;
    drv <= ~d;
    repeat (10) @(posedge clk_sys);
  endtask
endmodule

// ===== sim/test_host_command_status_port.sv
// Self-checking bench for the host command/status port
`timescale 1ns/100ps
module test_host_command_status_port;
  import hcs_pkg::*;
  logic clk_sys, reset_n, flash_card_busy, key_data_available, usb_busy, usb_buffer_full;
  logic usb_data_pending, result_valid, device_select_n, read_strobe_n, write_strobe_n;
  logic register_select_line, host_data_bus_oe, command_strobe, argument_strobe;
  logic result_taken, command_active, rd_done;
  logic [7:0] result_byte, host_data_bus_out, command_byte, argument_byte, status_byte, val;
  wire [7:0] host_data_bus_in;
  logic [8:0] rd_val;
  logic [9:0] notes[$];
  int errors, n_compared, seed, i, k;
  hcs_port #(.POWERUP_COUNT(40)) u_hcs_port (.clk_sys, .reset_n, .device_select_n,
    .read_strobe_n, .write_strobe_n, .register_select_line, .host_data_bus_in,
    .host_data_bus_out, .host_data_bus_oe, .flash_card_busy, .key_data_available, .usb_busy,
    .usb_buffer_full, .usb_data_pending, .result_byte, .result_valid, .command_byte,
    .command_strobe, .argument_byte, .argument_strobe, .result_taken, .command_active,
    .status_byte);
  hcs_host_model u_hcs_host_model (.clk_sys, .device_select_n, .read_strobe_n,
    .write_strobe_n, .register_select_line, .host_data_bus_in, .host_data_bus_out,
    .host_data_bus_oe, .rd_done, .rd_val);
  always #10 clk_sys = ~clk_sys;
  task automatic check(input string what, input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic take(input logic [9:0] got);
    logic [9:0] exp;
    exp = 10'hx;
    if (notes.size() > 0) exp = notes.pop_front();
    check("result", got, exp);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic acc(input logic cs, input logic sel, input logic wr, input logic [7:0] d);
    u_hcs_host_model.access(cs, sel, wr, d);
  endtask
  task automatic wait_ready();
    for (int n = 0; status_byte[ST_READY_POS] !== 1'b1; n++) begin
      if (n == 200) begin
        errors++;
        give_verdict();
      end
      @(posedge clk_sys);
    end
  endtask
  // Watches the outputs and pairs every result with the oldest note
  always @(posedge clk_sys) begin
    if (command_strobe === 1'b1) take({2'b00, command_byte});
    if (argument_strobe === 1'b1) take({2'b01, argument_byte});
    if (rd_done === 1'b1) take({1'b1, rd_val});
    if (result_taken === 1'b1) take({2'b10, result_byte});
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end
  initial begin
    seed = 51;
    {clk_sys, reset_n, flash_card_busy, key_data_available, usb_busy} = 5'h00;
    {usb_buffer_full, usb_data_pending, result_valid, result_byte} = 11'h000;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    notes.push_back(10'h300);
    acc(1'b1, REG_SEL_CMD, 1'b0, 8'h00);
    wait_ready();
    for (i = 0; i < 4; i++) begin
      val = 8'($random(seed));
      {usb_data_pending, usb_buffer_full, usb_busy, key_data_available, flash_card_busy} <= val[4:0];
      notes.push_back({2'b11, 2'b00, val[4:0], 1'b1});
      acc(1'b1, REG_SEL_CMD, 1'b0, 8'h00);
    end
    {usb_data_pending, usb_buffer_full, usb_busy, key_data_available, flash_card_busy} <= 5'h00;
    $display("done status");
    acc(1'b1, REG_SEL_DATA, 1'b1, 8'ha5);
    notes.push_back(10'h200);
    acc(1'b1, REG_SEL_DATA, 1'b0, 8'h00);
    acc(1'b0, REG_SEL_CMD, 1'b1, 8'h05);
    check("command_active", {9'h000, command_active}, 10'h000);
    $display("done idle");
    for (i = 0; i < 3; i++) begin
      val = 8'($random(seed));
      val[0] = 1'b1;
      notes.push_back({2'b00, val});
      acc(1'b1, REG_SEL_CMD, 1'b1, val);
      check("command_active", {9'h000, command_active}, 10'h001);
      for (k = 0; k < i; k++) begin
        val = 8'($random(seed));
        notes.push_back({2'b01, val});
        acc(1'b1, REG_SEL_DATA, 1'b1, val);
      end
      val = 8'($random(seed));
      result_byte <= val;
      result_valid <= i[0];
      if (i[0]) notes.push_back({2'b10, val});
      notes.push_back({2'b11, i[0] ? val : 8'h00});
      acc(1'b1, REG_SEL_DATA, 1'b0, 8'h00);
      acc(1'b1, REG_SEL_CMD, 1'b1, CMD_NOP);
      check("command_byte", {2'b00, command_byte}, {2'b00, CMD_NOP});
      check("command_active", {9'h000, command_active}, 10'h000);
    end
    $display("done commands");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("status_byte", {2'b00, status_byte}, 10'h000);
    reset_n <= 1'b1;
    wait_ready();
    notes.push_back(10'h301);
    acc(1'b1, REG_SEL_CMD, 1'b0, 8'h00);
    check("notes_left", 10'(notes.size()), 10'h000);
    $display("done reset");
    give_verdict();
  end
endmodule
